// ===== rtl/isc_start_gen.sv
// start and repeated-start generator with bus collision detection
module isc_start_gen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start_req,
  input  wire logic       rstart_req,
  input  wire logic [7:0] baud_reload_value,
  input  wire logic       bus_data_line_i,
  input  wire logic       bus_clock_line_i,
  output logic            bus_data_line_o,
  output logic            bus_data_line_oe,
  output logic            bus_clock_line_o,
  output logic            bus_clock_line_oe,
  output logic            bus_collision_flag,
  output logic            done,
  output logic            busy
);
  isc_pkg::isc_state_e st_q;
  isc_pkg::isc_state_e st_d;
  logic [1:0] sda_s_q;
  logic [1:0] scl_s_q;
  logic       sda_oe_q;
  logic       sda_oe_d;
  logic       scl_oe_q;
  logic       scl_oe_d;
  logic       col_q;
  logic       col_d;
  logic       done_q;
  logic       done_d;
  logic       busy_q;
  logic       busy_d;
  logic       brg_load;
  logic       brg_run;
  logic       brg_exp;
  logic       sda;
  logic       scl;

  assign sda = sda_s_q[1];
  assign scl = scl_s_q[1];

  isc_brg u_brg (
    .clk     (clk),
    .rst     (rst),
    .load    (brg_load),
    .run     (brg_run),
    .reload  (baud_reload_value),
    .expired (brg_exp)
  );

  always_comb
  begin
    st_d     = st_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = scl_oe_q;
    col_d    = 1'b0;
    done_d   = 1'b0;
    brg_load = 1'b0;
    brg_run  = 1'b0;
    case (st_q)
      isc_pkg::ST_IDLE:
      begin
        if (start_req)
        begin
          sda_oe_d = 1'b0;
          scl_oe_d = 1'b0;
          if (!sda || !scl)
          begin
            col_d = 1'b1;
          end
          else
          begin
            st_d = isc_pkg::ST_S_WAIT;
          end
        end
        else if (rstart_req)
        begin
          sda_oe_d = 1'b0;
          st_d     = isc_pkg::ST_R_REL;
        end
      end
      isc_pkg::ST_S_WAIT:
      begin
        if (sda)
        begin
          brg_load = 1'b1;
          st_d     = isc_pkg::ST_S_CNT1;
        end
      end
      isc_pkg::ST_S_CNT1:
      begin
        brg_run = 1'b1;
        if (!sda)
        begin
          brg_load = 1'b1;
          sda_oe_d = 1'b1;
          st_d     = isc_pkg::ST_S_CNT2;
        end
        else if (!scl)
        begin
          col_d = 1'b1;
          st_d  = isc_pkg::ST_IDLE;
        end
        else if (brg_exp)
        begin
          sda_oe_d = 1'b1;
          brg_load = 1'b1;
          st_d     = isc_pkg::ST_S_CNT2;
        end
      end
      isc_pkg::ST_S_CNT2:
      begin
        brg_run = 1'b1; // clock low ignored here
        if (brg_exp)
        begin
          scl_oe_d = 1'b1;
          done_d   = 1'b1;
          st_d     = isc_pkg::ST_HOLD;
        end
      end
      isc_pkg::ST_R_REL:
      begin
        if (sda)
        begin
          brg_load = 1'b1;
          st_d     = isc_pkg::ST_R_CNT0;
        end
      end
      isc_pkg::ST_R_CNT0:
      begin
        brg_run = 1'b1;
        if (brg_exp)
        begin
          scl_oe_d = 1'b0;
          st_d     = isc_pkg::ST_R_SCLH;
        end
      end
      isc_pkg::ST_R_SCLH:
      begin
        if (scl)
        begin
          if (!sda)
          begin
            col_d = 1'b1;
            st_d  = isc_pkg::ST_IDLE;
          end
          else
          begin
            brg_load = 1'b1;
            st_d     = isc_pkg::ST_R_CNT1;
          end
        end
      end
      isc_pkg::ST_R_CNT1:
      begin
        brg_run = 1'b1;
        if (!scl && sda)
        begin
          col_d = 1'b1;
          st_d  = isc_pkg::ST_IDLE;
        end
        else if (!sda)
        begin
          st_d = isc_pkg::ST_R_CNT1; // another master pulled data first: no collision
        end
        else if (brg_exp)
        begin
          sda_oe_d = 1'b1;
          brg_load = 1'b1;
          st_d     = isc_pkg::ST_R_CNT2;
        end
      end
      isc_pkg::ST_R_CNT2:
      begin
        brg_run = 1'b1;
        if (brg_exp)
        begin
          scl_oe_d = 1'b1; // regardless of clock state
          done_d   = 1'b1;
          st_d     = isc_pkg::ST_HOLD;
        end
      end
      isc_pkg::ST_HOLD:
      begin
        st_d = isc_pkg::ST_IDLE;
      end
      default:
      begin
        st_d = isc_pkg::ST_IDLE;
      end
    endcase
    if (col_d)
    begin
      sda_oe_d = 1'b0; // release both lines on collision
      scl_oe_d = 1'b0;
      st_d     = isc_pkg::ST_IDLE;
    end
    busy_d = st_d != isc_pkg::ST_IDLE;
  end

  // lines keep held low after a finished start so the next phase owns them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q     <= isc_pkg::ST_IDLE;
      sda_s_q  <= 2'h3;
      scl_s_q  <= 2'h3;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      col_q    <= 1'b0;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      sda_s_q  <= {sda_s_q[0], bus_data_line_i};
      scl_s_q  <= {scl_s_q[0], bus_clock_line_i};
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      col_q    <= col_d;
      done_q   <= done_d;
      busy_q   <= busy_d;
    end
  end

  assign bus_data_line_o    = 1'b0;
  assign bus_clock_line_o   = 1'b0;
  assign bus_data_line_oe   = sda_oe_q;
  assign bus_clock_line_oe  = scl_oe_q;
  assign bus_collision_flag = col_q;
  assign done               = done_q;
  assign busy               = busy_q;
endmodule : isc_start_gen

// ===== rtl/isc_pkg.sv
// constants and types for the i2c start / repeated-start generator with collision detect
package isc_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0]  RELOAD_RST = 8'h00;
  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_S_WAIT = 10'h002,
    ST_S_CNT1 = 10'h004,
    ST_S_CNT2 = 10'h008,
    ST_R_REL  = 10'h010,
    ST_R_CNT0 = 10'h020,
    ST_R_SCLH = 10'h040,
    ST_R_CNT1 = 10'h080,
    ST_R_CNT2 = 10'h100,
    ST_HOLD   = 10'h200
  } isc_state_e;
endpackage : isc_pkg

// ===== rtl/isc_brg.sv
// reloadable baud-rate down-counter that stops at zero and flags expiry while run is high
module isc_brg (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     load,
  input  wire logic                     run,
  input  wire logic [isc_pkg::CNT_W-1:0] reload,
  output logic                          expired
);
  logic [isc_pkg::CNT_W-1:0] cnt_q;
  logic [isc_pkg::CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
    begin
      cnt_d = reload;
    end
    else if (run && cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= isc_pkg::RELOAD_RST;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // expiry ignores load: the caller decides load from expiry, so using it here would form a loop
  assign expired = run && cnt_q == '0;
endmodule : isc_brg

// ===== verif/isc_peer_model.sv
// other bus master: holds lines low or clocks the bus at its own rate
module isc_peer_model (
  input  wire logic hold_sda,
  input  wire logic hold_scl,
  input  wire logic run_scl,
  output logic      sda_pull,
  output logic      scl_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick;
  // clock stands still between frames; the 3 ns skew keeps it off our edges
  initial
  begin
    tick = 1'b0;
    #3;
    forever #80 tick = run_scl ? ~tick : 1'b0;
  end
  assign sda_pull = hold_sda;
  // gate with run so the clock lets go at once when a frame is cut, not up to 80 ns later
  assign scl_pull = hold_scl | (tick & run_scl);
endmodule : isc_peer_model

// ===== verif/isc_start_gen_chk.sv
// port checks for the start generator
module isc_start_gen_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_req,
  input wire logic bus_data_line_i,
  input wire logic bus_clock_line_i,
  input wire logic bus_data_line_oe,
  input wire logic bus_clock_line_oe,
  input wire logic bus_collision_flag,
  input wire logic done,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // three cycles let the level clear the input synchronisers
  sequence s_low_req;
    ((!bus_data_line_i || !bus_clock_line_i) && !rst)[*3] ##0 (start_req && !busy);
  endsequence
  a_low_start: assert property (s_low_req |-> ##[1:3] bus_collision_flag)
    else $error("low line not flagged");
  a_flag_release: assert property (bus_collision_flag |->
    ##[0:1] !(bus_data_line_oe || bus_clock_line_oe)) else $error("lines kept");
  a_flag_idle: assert property (bus_collision_flag |-> ##[0:2] !busy)
    else $error("not idle after flag");
  a_flag_pulse: assert property (bus_collision_flag |=> !bus_collision_flag)
    else $error("flag too long");
  a_done_lines: assert property (done |-> bus_data_line_oe ##[0:1] bus_clock_line_oe)
    else $error("done with a line free");
  a_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  a_clock_last: assert property ($rose(bus_clock_line_oe) |-> bus_data_line_oe)
    else $error("clock before data");
  a_drive_busy: assert property ($rose(bus_data_line_oe) |-> busy)
    else $error("drive while idle");
endmodule : isc_start_gen_chk

// ===== verif/isc_start_gen_tb.sv
// self-checking bench for the start generator
module isc_start_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // rs repeat; ps/pc peer holds data/clock low; ls/lr peer grabs data/clocks at cycle 5
  typedef struct {logic rs; logic [7:0] rel; logic ps, pc, ls, lr, ef;} isc_row_s;
  isc_row_s   rows [9] = '{'{0, 8'h04, 0, 0, 0, 0, 0}, '{1, 8'h04, 0, 0, 0, 0, 0},
                           '{0, 8'h00, 0, 0, 0, 0, 0}, '{1, 8'h28, 0, 0, 0, 1, 1},
                           '{0, 8'h04, 1, 0, 0, 0, 1}, '{0, 8'h04, 0, 1, 0, 0, 1},
                           '{0, 8'h28, 0, 0, 0, 1, 1}, '{0, 8'h28, 0, 0, 1, 0, 0},
                           '{1, 8'h04, 0, 0, 1, 0, 1}};
  logic       clk, rst, start_req, rstart_req, hold_sda, hold_scl, run_scl, sda_pull, scl_pull;
  logic [7:0] baud_reload_value;
  logic       bus_data_line_o, bus_data_line_oe, bus_clock_line_o, bus_clock_line_oe;
  logic       bus_collision_flag, done, busy;
  int         n_fail, cmp_count, cyc;
  wire        bus_data_line_i = !(bus_data_line_oe || sda_pull);
  wire        bus_clock_line_i = !(bus_clock_line_oe || scl_pull);
  isc_start_gen  u_isc_start_gen (
    .clk                (clk),
    .rst                (rst),
    .start_req          (start_req),
    .rstart_req         (rstart_req),
    .baud_reload_value  (baud_reload_value),
    .bus_data_line_i    (bus_data_line_i),
    .bus_clock_line_i   (bus_clock_line_i),
    .bus_data_line_o    (bus_data_line_o),
    .bus_data_line_oe   (bus_data_line_oe),
    .bus_clock_line_o   (bus_clock_line_o),
    .bus_clock_line_oe  (bus_clock_line_oe),
    .bus_collision_flag (bus_collision_flag),
    .done               (done),
    .busy               (busy)
  );
  isc_peer_model u_isc_peer_model (
    .hold_sda (hold_sda),
    .hold_scl (hold_scl),
    .run_scl  (run_scl),
    .sda_pull (sda_pull),
    .scl_pull (scl_pull)
  );
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk_bit
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // each row starts from reset, so lines held by a finished start never leak on
  task automatic run_row(input isc_row_s r);
    int   n;
    int   g;
    logic f;
    logic d;
    @(posedge clk);
    rst <= 1'b1;
    hold_sda <= r.ps;
    hold_scl <= r.pc;
    run_scl <= 1'b0;
    baud_reload_value <= r.rel;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk_bit(busy | bus_data_line_oe | bus_clock_line_oe | done, 1'b0, "reset state");
    repeat (3) @(posedge clk);
    start_req <= !r.rs;
    rstart_req <= r.rs;
    n = 0;
    g = 0;
    f = 1'b0;
    d = 1'b0;
    while (!(f || d) && n < 1500)
    begin
      @(posedge clk);
      n++;
      start_req <= 1'b0;
      rstart_req <= 1'b0;
      if (n == 5)
      begin
        hold_sda <= r.ps | r.ls;
        run_scl <= r.lr;
      end
      #1;
      f = bus_collision_flag === 1'b1;
      d = done === 1'b1;
      if (bus_data_line_oe === 1'b1 && bus_clock_line_oe === 1'b0)
        g++;
    end
    chk_bit(f, r.ef, "collision flag");
    chk_bit(d, !r.ef, "completion");
    chk_bit(bus_data_line_o | bus_clock_line_o, 1'b0, "drive level");
    if (d)
      chk_bit(g >= r.rel + 1 && g <= r.rel + 3, 1'b1, "second count");
    if (r.ls && !r.rs)
      chk_bit(n < 2 * r.rel, 1'b1, "early data drive");
  endtask : run_row
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    rst = 1'b1;
    start_req = 1'b0;
    rstart_req = 1'b0;
    hold_sda = 1'b0;
    hold_scl = 1'b0;
    run_scl = 1'b0;
    baud_reload_value = 8'h00;
    repeat (10) @(posedge clk);
    foreach (rows[i])
      run_row(rows[i]);
    give_verdict();
  end
endmodule : isc_start_gen_tb
bind isc_start_gen isc_start_gen_chk u_isc_start_gen_chk (
  .clk                (clk),
  .rst                (rst),
  .start_req          (start_req),
  .bus_data_line_i    (bus_data_line_i),
  .bus_clock_line_i   (bus_clock_line_i),
  .bus_data_line_oe   (bus_data_line_oe),
  .bus_clock_line_oe  (bus_clock_line_oe),
  .bus_collision_flag (bus_collision_flag),
  .done               (done),
  .busy               (busy)
);
